// ### hdl/fce_core.v
// Fault classification, escalation, lockup and sleep-depth logic with its APB registers
`timescale 1ns/1ns
`include "fce_defs.vh"

// How it works
// - Vector-table read bus error raises hard fault and sets vector-read flag.
// - Any escalated fault sets the escalated flag and takes hard fault outside lockup and the hard fault and NMI handlers.
// - Map violation on instruction fetch raises memory fault, instruction-access flag.
// - Map violation on data load or store raises memory fault, data-access flag.
// - Map violation pushing or popping frame sets push or pop memory flag.
// - Bus error pushing or popping frame sets bus push or pop flag.
// - Prefetch bus error raises bus fault with prefetch flag.
// - Data bus error sets precise flag if attributable, else inexact flag.
// - Coprocessor, undefined opcode, bad execution state raise usage fault, own flags.
// - Bad return value, misaligned access, zero divisor each set own usage flag.
// - Fetch from never-execute region sets instruction flag even with protection off.
// - Configurable faults have software priority and individual handler enables.
// - Handler raising its own kind of fault escalates to hard fault.
// - Handler raising fault of equal or lower priority escalates it.
// - Any handler raising fault not above current priority escalates it.
// - Fault whose handler is disabled escalates to hard fault.
// - Bus error during bus fault handler entry push never escalates.
// - Hard fault is fixed top priority below only reset and NMI.
// - Data map violations and precise data bus errors record faulting address in their address register.
// - Hard fault inside NMI or hard fault handler enters lockup.
// - Lockup ends on reset, NMI or debug halt; NMI-entered lockup ignores NMI.
// - Control bit picks light sleep or deep sleep with clock, PLL, flash off.
// - Return value needs bits 31:4 set and low nibble 1, 9 or D.
module fce_core
#(
  parameter PRIW = 3
)
(
  input  wire            clk,
  input  wire            rst,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Fault events from pipeline, bus interface and protection unit (one-cycle pulses)
  input  wire            vectorReadBusErr,
  input  wire            fetchMapViol,
  input  wire            fetchNeverExec,
  input  wire            dataMapViol,
  input  wire            pushMapViol,
  input  wire            popMapViol,
  input  wire [31:0]     memFaultAddr,
  input  wire            prefetchBusErr,
  input  wire            preciseDataBusErr,
  input  wire            inexactDataBusErr,
  input  wire            pushBusErr,
  input  wire            popBusErr,
  input  wire [31:0]     busFaultAddr,
  input  wire            coprocAccess,
  input  wire            undefinedOpcode,
  input  wire            badExecState,
  input  wire            excReturnStrobe,
  input  wire [31:0]     exceptionReturnCode,
  input  wire            misalignedAccess,
  input  wire            zeroDivisor,
  // Execution context
  input  wire            inHandler,
  input  wire [PRIW-1:0] curPriority,
  input  wire [2:0]      curFaultKind,
  input  wire            inHardFaultHandler,
  input  wire            inNmiHandler,
  input  wire            busFaultEntryPush,
  input  wire            nmiReq,
  input  wire            debugHalt,
  input  wire            sleepReq,
  // Outcomes
  output reg             takeHardFault,
  output reg             takeMemFault,
  output reg             takeBusFault,
  output reg             takeUsageFault,
  output reg             lockup,
  output reg             cpuClkStop,
  output reg             sysClkStop,
  output reg             pllOff,
  output reg             flashOff
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [31:0] hardCause_q;
  reg [31:0] mmCause_q;
  reg [31:0] busCause_q;
  reg [31:0] useCause_q;
  reg [31:0] memmgmt_fault_addr_reg_q;
  reg [31:0] busAddr_q;
  reg [31:0] priority_q;
  reg [31:0] handlerEn_q;
  reg [31:0] system_control_reg_q;
  reg        lockNmi_q;

  // APB: access phase takes two cycles so that read data leaves a flop
  wire apbAccess = psel & penable;
  wire apbDone   = apbAccess & pready;
  wire apbWr     = apbDone & pwrite;

  // Write-one-to-clear masks, only when the transfer completes
  wire [31:0] clrHard = (apbWr && paddr == `FCE_OFS_HARD_CAUSE) ? pwdata : 32'h00000000;
  wire [31:0] clrMm   = (apbWr && paddr == `FCE_OFS_MM_CAUSE)   ? pwdata : 32'h00000000;
  wire [31:0] clrBus  = (apbWr && paddr == `FCE_OFS_BUS_CAUSE)  ? pwdata : 32'h00000000;
  wire [31:0] clrUse  = (apbWr && paddr == `FCE_OFS_USE_CAUSE)  ? pwdata : 32'h00000000;

  // ****************************************************************
  // Classification of raw events
  // ****************************************************************
  // Fetch violation counts whether from the map or a never-execute region
  wire instrViol  = fetchMapViol | fetchNeverExec;
  // Only three low-nibble encodings under an all-ones upper part are legal
  wire retOk = (exceptionReturnCode[31:4] == `FCE_RET_UPPER) &&
               (exceptionReturnCode[3:0] == `FCE_RET_HANDLER_MAIN ||
                exceptionReturnCode[3:0] == `FCE_RET_THREAD_MAIN  ||
                exceptionReturnCode[3:0] == `FCE_RET_THREAD_PROC);
  wire badReturn = excReturnStrobe & ~retOk;

  // Raise vector per kind: bit 0 memory, 1 bus, 2 usage
  wire [2:0] raise;
  assign raise[0] = instrViol | dataMapViol | pushMapViol | popMapViol;
  assign raise[1] = prefetchBusErr | preciseDataBusErr | inexactDataBusErr |
                    pushBusErr | popBusErr;
  assign raise[2] = coprocAccess | undefinedOpcode | badExecState |
                    badReturn | misalignedAccess | zeroDivisor;

  wire [PRIW-1:0] kindPri [0:2];
  assign kindPri[0] = priority_q[`FCE_PRI_MM_LSB +: PRIW];
  assign kindPri[1] = priority_q[`FCE_PRI_BUS_LSB +: PRIW];
  assign kindPri[2] = priority_q[`FCE_PRI_USE_LSB +: PRIW];
  wire [2:0] kindEn = {handlerEn_q[`FCE_EN_USE_BIT], handlerEn_q[`FCE_EN_BUS_BIT],
                       handlerEn_q[`FCE_EN_MM_BIT]};

  // ****************************************************************
  // Escalation, one slice per configurable kind
  // ****************************************************************
  // A lower priority number is more urgent; hard fault and NMI outrank all
  wire [2:0] escalate;
  wire [2:0] direct;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : gKind
      wire sameKind = inHandler & curFaultKind[k];
      wire notAbove = inHandler & (kindPri[k] >= curPriority);
      wire topCtx   = inHardFaultHandler | inNmiHandler;
      wire disabled = ~kindEn[k];
      // A failed push on entry to the bus fault handler still runs that handler
      wire exempt   = (k == 1) & busFaultEntryPush & pushBusErr;
      wire esc      = (sameKind | notAbove | topCtx | disabled) & ~exempt;
      assign escalate[k] = raise[k] & esc;
      assign direct[k]   = raise[k] & ~esc;
    end
  endgenerate

  wire hardRaise = vectorReadBusErr | (|escalate);
  wire hardInTop = hardRaise & (inHardFaultHandler | inNmiHandler);

  // ****************************************************************
  // Cause flags: sticky, set wins over a simultaneous clear
  // ****************************************************************
  reg [31:0] hardSet;
  reg [31:0] mmSet;
  reg [31:0] busSet;
  reg [31:0] useSet;
  always @*
  begin
    hardSet = 32'h00000000;
    mmSet   = 32'h00000000;
    busSet  = 32'h00000000;
    useSet  = 32'h00000000;
    hardSet[`FCE_HF_VECTOR_BIT]    = vectorReadBusErr;
    hardSet[`FCE_HF_ESCALATED_BIT] = |escalate;
    mmSet[`FCE_MM_INSTR_BIT]       = instrViol;
    mmSet[`FCE_MM_DATA_BIT]        = dataMapViol;
    mmSet[`FCE_MM_PUSH_BIT]        = pushMapViol;
    mmSet[`FCE_MM_POP_BIT]         = popMapViol;
    mmSet[`FCE_MM_ADDRVLD_BIT]     = dataMapViol;
    busSet[`FCE_BF_PUSH_BIT]       = pushBusErr;
    busSet[`FCE_BF_POP_BIT]        = popBusErr;
    busSet[`FCE_BF_PREFETCH_BIT]   = prefetchBusErr;
    busSet[`FCE_BF_PRECISE_BIT]    = preciseDataBusErr;
    busSet[`FCE_BF_INEXACT_BIT]    = inexactDataBusErr;
    busSet[`FCE_BF_ADDRVLD_BIT]    = preciseDataBusErr;
    useSet[`FCE_UF_COPROC_BIT]     = coprocAccess;
    useSet[`FCE_UF_UNDEFINED_OPCODE_FLAG_BIT]      = undefinedOpcode;
    useSet[`FCE_UF_BADSTATE_BIT]   = badExecState;
    useSet[`FCE_UF_BADRET_BIT]     = badReturn;
    useSet[`FCE_UF_MISALIGN_BIT]   = misalignedAccess;
    useSet[`FCE_UF_ZERODIV_BIT]    = zeroDivisor;
  end

  // Flags never self-clear on handler exit; only a software write does that
  always @(posedge clk)
  begin
    if (rst)
    begin
      hardCause_q <= `FCE_RST_WORD;
      mmCause_q   <= `FCE_RST_WORD;
      busCause_q  <= `FCE_RST_WORD;
      useCause_q  <= `FCE_RST_WORD;
    end
    else
    begin
      hardCause_q <= (hardCause_q & ~clrHard) | hardSet;
      mmCause_q   <= (mmCause_q & ~clrMm) | mmSet;
      busCause_q  <= (busCause_q & ~clrBus) | busSet;
      useCause_q  <= (useCause_q & ~clrUse) | useSet;
    end
  end

  // ****************************************************************
  // Fault address capture
  // ****************************************************************
  // Only precise accesses carry a meaningful address; inexact errors leave it alone
  always @(posedge clk)
  begin
    if (rst)
    begin
      memmgmt_fault_addr_reg_q  <= `FCE_RST_WORD;
      busAddr_q <= `FCE_RST_WORD;
    end
    else
    begin
      if (dataMapViol)
        memmgmt_fault_addr_reg_q <= memFaultAddr;
      if (preciseDataBusErr)
        busAddr_q <= busFaultAddr;
    end
  end

  // ****************************************************************
  // Handler selection and lockup
  // ****************************************************************
  // Hard fault wins; among configurable kinds the fixed order is memory, bus, usage
  always @(posedge clk)
  begin
    if (rst)
    begin
      takeHardFault  <= 1'b0;
      takeMemFault   <= 1'b0;
      takeBusFault   <= 1'b0;
      takeUsageFault <= 1'b0;
    end
    else
    begin
      takeHardFault  <= hardRaise & ~hardInTop & ~lockup;
      takeMemFault   <= direct[0] & ~hardRaise & ~lockup;
      takeBusFault   <= direct[1] & ~direct[0] & ~hardRaise & ~lockup;
      takeUsageFault <= direct[2] & ~direct[1] & ~direct[0] & ~hardRaise & ~lockup;
    end
  end

  // NMI releases lockup only when lockup did not start in the NMI handler
  always @(posedge clk)
  begin
    if (rst)
    begin
      lockup    <= 1'b0;
      lockNmi_q <= 1'b0;
    end
    else if (!lockup)
    begin
      if (hardInTop)
      begin
        lockup    <= 1'b1;
        lockNmi_q <= inNmiHandler;
      end
    end
    else if (debugHalt || (nmiReq && !lockNmi_q))
    begin
      lockup    <= 1'b0;
      lockNmi_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Sleep depth
  // ****************************************************************
  // Light sleep stops only the processor clock; deep sleep also the rest
  always @(posedge clk)
  begin
    if (rst)
    begin
      cpuClkStop <= 1'b0;
      sysClkStop <= 1'b0;
      pllOff     <= 1'b0;
      flashOff   <= 1'b0;
    end
    else
    begin
      cpuClkStop <= sleepReq;
      sysClkStop <= sleepReq & system_control_reg_q[`FCE_SC_DEEP_BIT];
      pllOff     <= sleepReq & system_control_reg_q[`FCE_SC_DEEP_BIT];
      flashOff   <= sleepReq & system_control_reg_q[`FCE_SC_DEEP_BIT];
    end
  end

  // ****************************************************************
  // APB slave: control registers and read path
  // ****************************************************************
  // Priority fields and enables are plain read/write; reset leaves all handlers off
  always @(posedge clk)
  begin
    if (rst)
    begin
      priority_q  <= `FCE_RST_WORD;
      handlerEn_q <= `FCE_RST_WORD;
      system_control_reg_q   <= `FCE_RST_WORD;
    end
    else if (apbWr)
    begin
      if (paddr == `FCE_OFS_PRIORITY)
        priority_q <= pwdata;
      if (paddr == `FCE_OFS_HANDLER_EN)
        handlerEn_q <= pwdata;
      if (paddr == `FCE_OFS_SYS_CTRL)
        system_control_reg_q <= pwdata;
    end
  end

  reg [31:0] rdMux;
  reg        rdBad;
  always @*
  begin
    rdMux = 32'h00000000;
    rdBad = 1'b0;
    case (paddr)
      `FCE_OFS_HARD_CAUSE:  rdMux = hardCause_q;
      `FCE_OFS_MM_CAUSE:    rdMux = mmCause_q;
      `FCE_OFS_BUS_CAUSE:   rdMux = busCause_q;
      `FCE_OFS_USE_CAUSE:   rdMux = useCause_q;
      `FCE_OFS_MM_ADDR:     rdMux = memmgmt_fault_addr_reg_q;
      `FCE_OFS_BUS_ADDR:    rdMux = busAddr_q;
      `FCE_OFS_PRIORITY:    rdMux = priority_q;
      `FCE_OFS_HANDLER_EN:  rdMux = handlerEn_q;
      `FCE_OFS_SYS_CTRL:    rdMux = system_control_reg_q;
      `FCE_OFS_CORE_STATUS: rdMux = {30'h0, lockNmi_q, lockup};
      default:              rdBad = 1'b1;
    endcase
  end

  // First access cycle loads the answer, second completes with pready high
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (apbAccess && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rdMux;
      pslverr <= rdBad;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

endmodule

// ### hdl/fce_defs.vh
// Register offsets, field positions and reset values of the fault classify and escalate unit
`ifndef FCE_DEFS_VH
`define FCE_DEFS_VH

// ****************************************************************
// Register byte offsets on the APB slave
// ****************************************************************
`define FCE_OFS_HARD_CAUSE   8'h00
`define FCE_OFS_MM_CAUSE     8'h04
`define FCE_OFS_BUS_CAUSE    8'h08
`define FCE_OFS_USE_CAUSE    8'h0C
`define FCE_OFS_MM_ADDR      8'h10
`define FCE_OFS_BUS_ADDR     8'h14
`define FCE_OFS_PRIORITY     8'h18
`define FCE_OFS_HANDLER_EN   8'h1C
`define FCE_OFS_SYS_CTRL     8'h20
`define FCE_OFS_CORE_STATUS  8'h24

// ****************************************************************
// Field positions
// ****************************************************************
// hard_fault_cause_reg
`define FCE_HF_VECTOR_BIT    1
`define FCE_HF_ESCALATED_BIT 30
// memmgmt_fault_cause_reg
`define FCE_MM_INSTR_BIT     0
`define FCE_MM_DATA_BIT      1
`define FCE_MM_POP_BIT       3
`define FCE_MM_PUSH_BIT      4
`define FCE_MM_ADDRVLD_BIT   7
// bus_fault_cause_reg
`define FCE_BF_PREFETCH_BIT  0
`define FCE_BF_PRECISE_BIT   1
`define FCE_BF_INEXACT_BIT   2
`define FCE_BF_POP_BIT       3
`define FCE_BF_PUSH_BIT      4
`define FCE_BF_ADDRVLD_BIT   7
// usage_fault_cause_reg
`define FCE_UF_UNDEFINED_OPCODE_FLAG_BIT     0
`define FCE_UF_BADSTATE_BIT  1
`define FCE_UF_BADRET_BIT    2
`define FCE_UF_COPROC_BIT    3
`define FCE_UF_MISALIGN_BIT  8
`define FCE_UF_ZERODIV_BIT   9
// fault_priority_reg: one field per configurable kind, 8 bits apart
`define FCE_PRI_MM_LSB       0
`define FCE_PRI_BUS_LSB      8
`define FCE_PRI_USE_LSB      16
// handler_enable_reg
`define FCE_EN_MM_BIT        16
`define FCE_EN_BUS_BIT       17
`define FCE_EN_USE_BIT       18
// system_control_reg
`define FCE_SC_DEEP_BIT      2
// core status
`define FCE_ST_LOCKUP_BIT    0
`define FCE_ST_LOCKNMI_BIT   1

// ****************************************************************
// Exception return encoding
// ****************************************************************
`define FCE_RET_UPPER        28'hFFFFFFF
`define FCE_RET_HANDLER_MAIN 4'h1
`define FCE_RET_THREAD_MAIN  4'h9
`define FCE_RET_THREAD_PROC  4'hD

// ****************************************************************
// Reset values
// ****************************************************************
`define FCE_RST_WORD         32'h00000000

`endif

// ### verif/fault_classify_escalate_test.sv
// Self-checking bench for the fault classify and escalate unit
`timescale 1ns/1ns
// ****************************************************************
// Bench
// ****************************************************************
module fault_classify_escalate_test;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, go, rdErr, esc, bad;
  logic        inHandler, inHardFaultHandler, inNmiHandler, busFaultEntryPush, nmiReq;
  logic        debugHalt, sleepReq, takeHardFault, takeMemFault, takeBusFault, takeUsageFault;
  logic        lockup, cpuClkStop, sysClkStop, pllOff, flashOff;
  logic [7:0]  paddr, code;
  logic [31:0] pwdata, prdata, rdData, addrIn, bus_fault_addr_reg, exceptionReturnCode, priWord, expW;
  logic [4:0]  sel;
  logic [16:0] ev;
  logic [2:0]  curPriority, curFaultKind, pri;
  int          nErrors, comparisons, seed, e;
  // Cause register (top two bits) and flag position of each event, return check last
  logic [7:0]  causeMap [17] = '{8'h01, 8'h40, 8'h40, 8'h41, 8'h44, 8'h43, 8'h80, 8'h81,
    8'h82, 8'h84, 8'h83, 8'hC3, 8'hC0, 8'hC1, 8'hC8, 8'hC9, 8'hC2};
  logic [31:0] retCodes [6] = '{32'hFFFFFFF1, 32'hFFFFFFF9, 32'hFFFFFFFD, 32'hFFFFFFF0,
    32'h7FFFFFF9, 32'hFFFFFFFE};

  fce_event_source i_src (.clk, .rst, .go, .sel, .addrIn, .ev, .bus_fault_addr_reg);
  fce_core #(.PRIW(3)) i_dut
  (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vectorReadBusErr(ev[0]), .fetchMapViol(ev[1]), .fetchNeverExec(ev[2]),
    .dataMapViol(ev[3]), .pushMapViol(ev[4]), .popMapViol(ev[5]), .prefetchBusErr(ev[6]),
    .preciseDataBusErr(ev[7]), .inexactDataBusErr(ev[8]), .pushBusErr(ev[9]),
    .popBusErr(ev[10]), .coprocAccess(ev[11]), .undefinedOpcode(ev[12]),
    .badExecState(ev[13]), .misalignedAccess(ev[14]), .zeroDivisor(ev[15]),
    .excReturnStrobe(ev[16]), .exceptionReturnCode, .memFaultAddr(bus_fault_addr_reg),
    .busFaultAddr(bus_fault_addr_reg), .inHandler, .curPriority, .curFaultKind, .inHardFaultHandler,
    .inNmiHandler, .busFaultEntryPush, .nmiReq, .debugHalt, .sleepReq, .takeHardFault,
    .takeMemFault, .takeBusFault, .takeUsageFault, .lockup, .cpuClkStop, .sysClkStop,
    .pllOff, .flashOff
  );

  // Expected flag word: own flag, plus address valid for captured addresses
  function automatic logic [31:0] causeWord(input int i);
    return (32'h00000001 << causeMap[i][5:0]) | ((i == 3 || i == 7) ? 32'h00000080 : 32'h0);
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      chk("pready", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", exp, rdData);
  endtask

  task automatic clrAll;
    for (int r = 0; r < 4; r++)
      apb(1'b1, 8'(4 * r), 32'hFFFFFFFF);
  endtask

  // Event appears one cycle after the request; takes are seen one cycle after that
  task automatic fire(input int i, input logic [3:0] exp);
    @(posedge clk);
    go     <= 1'b1;
    sel    <= 5'(i);
    addrIn <= $urandom;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk("takes", {28'h0, exp}, {28'h0, takeHardFault, takeMemFault, takeBusFault, takeUsageFault});
  endtask

  task automatic kick(input logic nmi, input logic halt);
    @(posedge clk);
    nmiReq    <= nmi;
    debugHalt <= halt;
    @(posedge clk);
    nmiReq    <= 1'b0;
    debugHalt <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, go, inHandler, inHardFaultHandler, inNmiHandler} = 7'h00;
    {busFaultEntryPush, nmiReq, debugHalt, sleepReq, paddr, sel, curPriority} = 20'h00000;
    {pwdata, addrIn, exceptionReturnCode, curFaultKind} = 99'h0;
    seed = $urandom(22);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 10; r++)
      rdChk(8'(4 * r), 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rdErr});
    $display("test reset done");
    priWord = $urandom & 32'h00030707;
    apb(1'b1, 8'h18, priWord);
    apb(1'b1, 8'h1C, 32'h00070000);
    rdChk(8'h18, priWord);
    for (int i = 0; i < 22; i++)
    begin
      exceptionReturnCode <= retCodes[i % 6];
      e = (i < 16) ? i : 16;
      code = causeMap[e];
      bad = (i < 16) || retCodes[i % 6][31:4] != 28'hFFFFFFF
        || !(retCodes[i % 6][3:0] inside {4'h1, 4'h9, 4'hD});
      expW = bad ? causeWord(e) : 32'h0;
      fire(e, bad ? (4'h8 >> code[7:6]) : 4'h0);
      rdChk(8'(4 * code[7:6]), expW);
      if (i == 3 || i == 7)
        rdChk((i == 3) ? 8'h10 : 8'h14, addrIn);
      clrAll();
    end
    fire(12, 4'h1);
    fire(15, 4'h1);
    rdChk(8'h0C, 32'h00000201);
    clrAll();
    $display("test classify done");
    inHandler <= 1'b1;
    for (int j = 0; j < 8; j++)
    begin
      pri = (j == 0) ? priWord[18:16] : ((j == 1) ? 3'h7 : ((j == 2) ? 3'h0 : 3'($urandom)));
      curPriority  <= pri;
      curFaultKind <= (j == 1) ? 3'h4 : 3'h1;
      esc = (j < 3) || priWord[18:16] >= pri;
      fire((j == 2) ? 0 : 12, esc ? 4'h8 : 4'h1);
      rdChk(8'h00, esc ? ((j == 2) ? 32'h2 : 32'h40000000) : 32'h0);
      clrAll();
    end
    inHandler <= 1'b0;
    apb(1'b1, 8'h1C, 32'h00010000);
    fire(12, 4'h8);
    busFaultEntryPush <= 1'b1;
    fire(9, 4'h2);
    busFaultEntryPush <= 1'b0;
    fire(9, 4'h8);
    rdChk(8'h00, 32'h40000000);
    clrAll();
    $display("test escalate done");
    apb(1'b1, 8'h1C, 32'h00070000);
    inHardFaultHandler <= 1'b1;
    fire(0, 4'h0);
    chk("lockup", 32'h1, {31'h0, lockup});
    inHardFaultHandler <= 1'b0;
    fire(12, 4'h0);
    rdChk(8'h0C, 32'h1);
    rdChk(8'h24, 32'h1);
    kick(1'b1, 1'b0);
    chk("lockup", 32'h0, {31'h0, lockup});
    inNmiHandler <= 1'b1;
    fire(12, 4'h0);
    rdChk(8'h24, 32'h3);
    kick(1'b1, 1'b0);
    chk("lockup", 32'h1, {31'h0, lockup});
    kick(1'b0, 1'b1);
    chk("lockup", 32'h0, {31'h0, lockup});
    inNmiHandler <= 1'b0;
    clrAll();
    $display("test lockup done");
    sleepReq <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("sleep", 32'h8, {28'h0, cpuClkStop, sysClkStop, pllOff, flashOff});
    apb(1'b1, 8'h20, 32'h00000004);
    repeat (2) @(posedge clk);
    #1;
    chk("sleep", 32'hF, {28'h0, cpuClkStop, sysClkStop, pllOff, flashOff});
    sleepReq <= 1'b0;
    $display("test sleep done");
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule

// ### verif/fce_core_checker.sv
// Concurrent checks on the ports of the fault classify and escalate unit
`timescale 1ns/1ns
// ****************************************************************
// Checker
// ****************************************************************
module fce_checker
(
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        vectorReadBusErr,
  input wire        pushBusErr,
  input wire        undefinedOpcode,
  input wire        excReturnStrobe,
  input wire [31:0] exceptionReturnCode,
  input wire        inHandler,
  input wire [2:0]  curFaultKind,
  input wire        inHardFaultHandler,
  input wire        inNmiHandler,
  input wire        busFaultEntryPush,
  input wire        nmiReq,
  input wire        debugHalt,
  input wire        sleepReq,
  input wire        takeHardFault,
  input wire        takeMemFault,
  input wire        takeBusFault,
  input wire        takeUsageFault,
  input wire        lockup,
  input wire        cpuClkStop,
  input wire        sysClkStop,
  input wire        pllOff,
  input wire        flashOff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Outside the fault and NMI handlers and outside lockup, events are taken plainly
  wire quiet = !inHardFaultHandler && !inNmiHandler && !lockup;
  wire anyTake = takeHardFault || takeMemFault || takeBusFault || takeUsageFault;

  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_vector_hard: assert property (vectorReadBusErr && quiet |=> takeHardFault)
    else $error("vector read error took no hard fault");
  a_same_kind: assert property (undefinedOpcode && quiet && inHandler
    && curFaultKind[2] |=> takeHardFault && !takeUsageFault)
    else $error("same kind fault not escalated");
  a_push_kept: assert property (pushBusErr && busFaultEntryPush && quiet
    && !vectorReadBusErr |=> !takeHardFault) else $error("entry push error escalated");
  a_hf_lockup: assert property (vectorReadBusErr && inHardFaultHandler && !lockup
    |=> lockup && !takeHardFault) else $error("hard fault in handler did not lock up");
  a_lock_silent: assert property (lockup && $past(lockup) |-> !anyTake)
    else $error("handler taken in lockup");
  a_lock_stays: assert property (lockup && !debugHalt && !nmiReq |=> lockup)
    else $error("lockup left without cause");
  a_halt_exit: assert property (lockup && debugHalt |=> !lockup)
    else $error("debug halt did not end lockup");
  a_bad_return: assert property (excReturnStrobe && quiet
    && exceptionReturnCode[31:4] != 28'hFFFFFFF |=> takeUsageFault || takeHardFault)
    else $error("bad return value not faulted");
  a_sleep_follow: assert property (1'b1 |=> cpuClkStop == $past(sleepReq))
    else $error("processor clock stop does not follow sleep request");
  a_deep_group: assert property (sysClkStop == pllOff && pllOff == flashOff)
    else $error("deep sleep outputs disagree");

  c_hard: cover property (takeHardFault);
  c_lock_nmi: cover property (lockup && nmiReq);
  c_deep: cover property (sysClkStop);
  c_unmapped: cover property (pslverr);
endmodule

bind fce_core fce_checker i_chk
(
  .clk, .rst, .psel, .penable, .pready, .pslverr, .vectorReadBusErr, .pushBusErr,
  .undefinedOpcode, .excReturnStrobe, .exceptionReturnCode, .inHandler, .curFaultKind,
  .inHardFaultHandler, .inNmiHandler, .busFaultEntryPush, .nmiReq, .debugHalt, .sleepReq,
  .takeHardFault, .takeMemFault, .takeBusFault, .takeUsageFault, .lockup, .cpuClkStop,
  .sysClkStop, .pllOff, .flashOff
);

// ### verif/fce_event_source.sv
// Stand-in for pipeline, bus interface and protection unit raising fault events
`timescale 1ns/1ns
// ****************************************************************
// Event source model
// ****************************************************************
module fce_event_source
(
  input  wire        clk,
  input  wire        rst,
  input  wire        go,
  input  wire [4:0]  sel,
  input  wire [31:0] addrIn,
  output reg  [16:0] ev,
  output reg  [31:0] bus_fault_addr_reg
);
  // One event per request, one cycle long; the address inverts every cycle once released so a
  // stale capture can never pass for a fresh one
  always @(posedge clk)
  begin
    if (rst)
    begin
      ev        <= 17'h00000;
      bus_fault_addr_reg <= 32'h00000000;
    end
    else
    begin
      ev        <= go ? (17'h00001 << sel) : 17'h00000;
      bus_fault_addr_reg <= go ? addrIn : ~bus_fault_addr_reg;
    end
  end
endmodule
